// ### hdl/serial_access_pkg.sv
/*
  Constants, register map and carrier types for the four-wire serial
  register access port. Assumes a single system clock domain; the serial
  pins arrive asynchronously and are synchronised by the port itself.
*/
package serial_access_pkg;

  // Frame layout
  localparam int          HEADER_BITS   = 16;   // Direction bit plus 15 address bits
  localparam int          BYTE_BITS     = 8;
  localparam logic [4:0]  HEADER_LAST   = 5'h0F;
  localparam logic [2:0]  BYTE_LAST     = 3'h7;

  // Field positions
  localparam int          ASCEND_BIT_HI = 5;    // interface_config mirror bits
  localparam int          ASCEND_BIT_LO = 2;
  localparam int          HOLD_BIT      = 0;    // user_serial_config address hold

  // Addresses the logic refers to by name
  localparam logic [14:0] ADDR_INTERFACE_CONFIG   = 15'h0000;
  localparam logic [14:0] ADDR_PART_TYPE_CODE     = 15'h0003;
  localparam logic [14:0] ADDR_PART_ID            = 15'h0004;
  localparam logic [14:0] ADDR_MAKER_ID_LO        = 15'h000C;
  localparam logic [14:0] ADDR_MAKER_ID_HI        = 15'h000D;
  localparam logic [14:0] ADDR_USER_SERIAL_CONFIG = 15'h0010;
  localparam logic [14:0] ADDR_SYNC_CAPTURE_POS   = 15'h002C;
  localparam logic [14:0] ADDR_FULL_SCALE_A_LO    = 15'h0030;
  localparam logic [14:0] ADDR_FULL_SCALE_A_HI    = 15'h0031;
  localparam logic [14:0] ADDR_CALIBRATION_ENABLE = 15'h0061;
  localparam logic [14:0] ADDR_CALIBRATION_STATE  = 15'h006A;

  // Trim bytes normally come from fuses; a plain value stands in here
  localparam logic [7:0]  TRIM_DEFAULT  = 8'h00;

  // Writable byte locations; a 16-bit register occupies two, low byte first
  localparam int NUM_RW = 38;
  localparam logic [14:0] RW_ADDR [NUM_RW] = '{
    ADDR_INTERFACE_CONFIG, 15'h0002, ADDR_USER_SERIAL_CONFIG, 15'h0029,
    15'h002A, 15'h002B, ADDR_FULL_SCALE_A_LO, ADDR_FULL_SCALE_A_HI,
    15'h0032, 15'h0033, 15'h0038, 15'h003B, 15'h0048, 15'h004F,
    15'h0060, ADDR_CALIBRATION_ENABLE, 15'h0062, 15'h0064, 15'h0068,
    15'h006B, 15'h006C, 15'h006E, 15'h0070, 15'h0071, 15'h007A,
    15'h007B, 15'h007C, 15'h007E, 15'h007F, 15'h009D, 15'h0102,
    15'h0103, 15'h0112, 15'h0113, 15'h0142, 15'h0152, 15'h0160,
    15'h0200
  };
  localparam logic [7:0] RW_RESET [NUM_RW] = '{
    8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h00, 8'hA0,
    8'h00, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h13, 8'h01, 8'h01,
    8'h01, 8'h02, 8'h61, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT, TRIM_DEFAULT,
    TRIM_DEFAULT, TRIM_DEFAULT, 8'h00, 8'h01
  };

  typedef struct packed {
    logic selectN;
    logic serialClk;
    logic serialIn;
  } serial_pins_t;

  typedef struct packed {
    logic serialOut;
    logic serialOutEn;
  } serial_drive_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_HEADER = 2'b01,
    PH_DATA   = 2'b10
  } phase_t;

endpackage : serial_access_pkg

// ### hdl/serial_register_access_port.sv
/*
  Four-wire serial register access port with single and streaming
  read/write frames and the device register file behind it.
  Assumes the serial pins are asynchronous to sys_clk and that the serial
  clock is at least several sys_clk periods per phase; the two status
  inputs are already in the sys_clk domain.
*/
`timescale 1ns/100ps

// Summary of operation
// - Transfers only while select is held low
// - Serial input captured on rising serial clock
// - No timeout; any slow serial clock works
// - Frame is 24 bits: direction, address, data
// - All fields shifted most significant bit first
// - Wide registers little-endian, low byte first
// - Output undriven in writes and read header
// - First bit one reads, zero writes
// - Next 15 bits give register address
// - Write stores last eight bits at address
// - Read ignores input, drives register on output
// - Streaming moves further bytes while select low
// - Streaming steps address up or down
// - Interface config bits 5,2 choose step direction
// - Address hold bit stops address advance
module serial_register_access_port #(
  parameter logic [7:0]  PART_TYPE_VALUE = 8'h5A,   // Arbitrary value
  parameter logic [7:0]  PART_ID_VALUE   = 8'hA5,   // Arbitrary value
  parameter logic [15:0] MAKER_ID_VALUE  = 16'h1234 // Arbitrary value
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rstn,
  input  wire serial_access_pkg::serial_pins_t pins,
  output serial_access_pkg::serial_drive_t   drive,
  input  wire logic [7:0]                    syncCapturePosition,
  input  wire logic [7:0]                    calibrationState,
  output logic [7:0]                         calibrationEnable,
  output logic [15:0]                        fullScaleRangeA
);

  typedef struct packed {
    logic [1:0]                                     selSync;
    logic [1:0]                                     clkSync;
    logic [1:0]                                     dinSync;
    logic                                           clkLast;
    serial_access_pkg::phase_t                      phase;
    logic [4:0]                                     headerCnt;
    logic [2:0]                                     byteCnt;
    logic [13:0]                                    shift;
    logic                                           isRead;
    logic [14:0]                                    addr;
    logic [7:0]                                     outShift;
    logic                                           outBit;
    logic                                           outEn;
    logic [serial_access_pkg::NUM_RW-1:0][7:0]      regs;
  } state_t;

  function automatic state_t resetState();
    state_t s;
    s = '0;
    s.selSync = 2'h3;
    s.phase   = serial_access_pkg::PH_IDLE;
    for (int i = 0; i < serial_access_pkg::NUM_RW; i++) begin
      s.regs[i] = serial_access_pkg::RW_RESET[i];
    end
    return s;
  endfunction : resetState

  localparam state_t STATE_RESET = resetState();

  // Returns {hit, slot} for a writable location
  function automatic logic [6:0] findSlot(input logic [14:0] a);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < serial_access_pkg::NUM_RW; i++) begin
      if (serial_access_pkg::RW_ADDR[i] == a) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction : findSlot

  function automatic logic [7:0] slotValue(
    input logic [serial_access_pkg::NUM_RW-1:0][7:0] regs,
    input logic [14:0]                               a
  );
    logic [6:0] s;
    s = findSlot(a);
    return s[6] ? regs[s[5:0]] : 8'h00;
  endfunction : slotValue

  state_t st_q;
  state_t st_d;

  logic       selLow;
  logic       clkRise;
  logic       clkFall;
  logic       din;
  logic       ascend;
  logic       hold;
  logic [7:0] readData;
  logic [7:0] writeByte;
  logic [6:0] wrSlot;
  logic [14:0] nextAddr;
  logic [14:0] headerAddr;
  logic [7:0] ifCfg;
  logic [7:0] usrCfg;

  // Read mux over writable bytes, identity codes and live status
  function automatic logic [7:0] readByte(
    input logic [serial_access_pkg::NUM_RW-1:0][7:0] regs,
    input logic [14:0]                               a,
    input logic [7:0]                                syncPos,
    input logic [7:0]                                calState
  );
    logic [7:0] v;
    v = slotValue(regs, a);
    case (a)
      serial_access_pkg::ADDR_PART_TYPE_CODE:    v = PART_TYPE_VALUE;
      serial_access_pkg::ADDR_PART_ID:           v = PART_ID_VALUE;
      serial_access_pkg::ADDR_MAKER_ID_LO:       v = MAKER_ID_VALUE[7:0];
      serial_access_pkg::ADDR_MAKER_ID_HI:       v = MAKER_ID_VALUE[15:8];
      serial_access_pkg::ADDR_SYNC_CAPTURE_POS:  v = syncPos;
      serial_access_pkg::ADDR_CALIBRATION_STATE: v = calState;
      default:                                   v = v;
    endcase
    return v;
  endfunction : readByte

  always_comb begin
    st_d = st_q;

    // Two flops on each pin; only the second stage is used below
    st_d.selSync = {st_q.selSync[0], pins.selectN};
    st_d.clkSync = {st_q.clkSync[0], pins.serialClk};
    st_d.dinSync = {st_q.dinSync[0], pins.serialIn};
    st_d.clkLast = st_q.clkSync[1];

    selLow  = ~st_q.selSync[1];
    clkRise = st_q.clkSync[1] & ~st_q.clkLast;
    clkFall = ~st_q.clkSync[1] & st_q.clkLast;
    din     = st_q.dinSync[1];

    ifCfg  = slotValue(st_q.regs, serial_access_pkg::ADDR_INTERFACE_CONFIG);
    usrCfg = slotValue(st_q.regs, serial_access_pkg::ADDR_USER_SERIAL_CONFIG);
    ascend = ifCfg[serial_access_pkg::ASCEND_BIT_HI]
           | ifCfg[serial_access_pkg::ASCEND_BIT_LO];
    hold   = usrCfg[serial_access_pkg::HOLD_BIT];

    headerAddr = {st_q.shift, din};
    writeByte  = {st_q.shift[6:0], din};
    wrSlot     = findSlot(st_q.addr);

    if (hold) begin
      nextAddr = st_q.addr;
    end else if (ascend) begin
      nextAddr = 15'(st_q.addr + 15'h0001);
    end else begin
      nextAddr = 15'(st_q.addr - 15'h0001);
    end

    readData = readByte(st_q.regs, nextAddr, syncCapturePosition, calibrationState);

    if (!selLow) begin
      // Frame aborted or finished; the next low starts a new header
      st_d.phase     = serial_access_pkg::PH_IDLE;
      st_d.headerCnt = 5'h00;
      st_d.byteCnt   = 3'h0;
      st_d.outEn     = 1'b0;
      st_d.outBit    = 1'b0;
    end else begin
      if (st_q.phase == serial_access_pkg::PH_IDLE) begin
        st_d.phase = serial_access_pkg::PH_HEADER;
      end
      case (st_q.phase)
        serial_access_pkg::PH_IDLE,
        serial_access_pkg::PH_HEADER: begin
          if (clkRise) begin
            st_d.shift     = {st_q.shift[12:0], din};
            st_d.headerCnt = 5'(st_q.headerCnt + 5'h01);
            if (st_q.headerCnt == 5'h00) begin
              // Direction bit would fall out of the 14-bit shifter
              st_d.isRead = din;
            end
            if (st_q.headerCnt == serial_access_pkg::HEADER_LAST) begin
              st_d.addr     = headerAddr;
              st_d.outShift = readByte(st_q.regs, headerAddr,
                                       syncCapturePosition, calibrationState);
              st_d.byteCnt  = 3'h0;
              st_d.phase    = serial_access_pkg::PH_DATA;
            end
          end
        end
        serial_access_pkg::PH_DATA: begin
          if (clkFall && st_q.isRead) begin
            // Change on the falling edge so the host samples a settled bit
            st_d.outEn    = 1'b1;
            st_d.outBit   = st_q.outShift[7];
            st_d.outShift = {st_q.outShift[6:0], 1'b0};
          end
          if (clkRise) begin
            st_d.shift   = {st_q.shift[12:0], din};
            st_d.byteCnt = 3'(st_q.byteCnt + 3'h1);
            if (st_q.byteCnt == serial_access_pkg::BYTE_LAST) begin
              // Read-only and unlisted locations silently drop writes
              if (!st_q.isRead && wrSlot[6]) begin
                st_d.regs[wrSlot[5:0]] = writeByte;
              end
              st_d.addr     = nextAddr;
              st_d.outShift = readData;
            end
          end
        end
        default: begin
          st_d.phase = serial_access_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Edges are found by sampling, so a stopped serial clock just waits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign drive.serialOut   = st_q.outBit;
  assign drive.serialOutEn = st_q.outEn;
  assign calibrationEnable = slotValue(st_q.regs, serial_access_pkg::ADDR_CALIBRATION_ENABLE);
  assign fullScaleRangeA   = {slotValue(st_q.regs, serial_access_pkg::ADDR_FULL_SCALE_A_HI),
                              slotValue(st_q.regs, serial_access_pkg::ADDR_FULL_SCALE_A_LO)};

endmodule : serial_register_access_port

// ### testbench/serial_port_checker.sv
/*
  Concurrent checks on the pins and register outputs of the serial port.
  Assumes it is bound to the port's top module and that host clock edges
  never coincide with sys_clk edges.
*/
`timescale 1ns/100ps
module serial_port_checker (
  input  wire logic                             sys_clk,
  input  wire logic                             rstn,
  input  wire serial_access_pkg::serial_pins_t  pins,
  input  wire serial_access_pkg::serial_drive_t drive,
  input  wire logic [7:0]                       calibrationEnable,
  input  wire logic [15:0]                      fullScaleRangeA
);
  logic       clkQ;
  logic       dirQ;
  logic [7:0] edgeCnt;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Raw edges lead the port's synchroniser, so this count is never late
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clkQ    <= 1'b0;
      dirQ    <= 1'b0;
      edgeCnt <= 8'h00;
    end else begin
      clkQ <= pins.serialClk;
      if (pins.selectN) begin
        edgeCnt <= 8'h00;
      end else if (pins.serialClk && !clkQ) begin
        edgeCnt <= edgeCnt + 8'h01;
        if (edgeCnt == 8'h00) begin
          dirQ <= pins.serialIn;
        end
      end
    end
  end

  sequence s_deselected;
    pins.selectN [*4];
  endsequence
  sequence s_byte_edge;
    !pins.selectN && edgeCnt >= 8'h18 && edgeCnt[2:0] == 3'h0;
  endsequence

  property p_off_after_select;
    s_deselected |-> !drive.serialOutEn;
  endproperty
  property p_out_needs_select;
    $rose(drive.serialOutEn) |-> !pins.selectN;
  endproperty
  property p_out_after_header;
    drive.serialOutEn && !pins.selectN |-> dirQ && edgeCnt >= 8'h10;
  endproperty
  property p_shift_on_low;
    drive.serialOutEn && $changed(drive.serialOut) |-> !pins.serialClk;
  endproperty
  property p_en_rise_low;
    $rose(drive.serialOutEn) |-> !pins.serialClk && edgeCnt[2:0] == 3'h0;
  endproperty
  property p_write_in_frame;
    $changed(calibrationEnable) |-> !dirQ && !pins.selectN;
  endproperty
  property p_write_on_byte;
    $changed(calibrationEnable) |-> s_byte_edge;
  endproperty
  property p_fsr_on_byte;
    $changed(fullScaleRangeA) |-> s_byte_edge ##0 !dirQ;
  endproperty

  a_off_after_select: assert property (p_off_after_select)
    else $error("output enabled while deselected");
  a_out_needs_select: assert property (p_out_needs_select)
    else $error("output enabled without select");
  a_out_after_header: assert property (p_out_after_header)
    else $error("output driven outside read data");
  a_shift_on_low: assert property (p_shift_on_low)
    else $error("read data moved while clock high");
  a_en_rise_low: assert property (p_en_rise_low)
    else $error("output enabled off a byte boundary");
  a_write_in_frame: assert property (p_write_in_frame)
    else $error("register changed outside a write frame");
  a_write_on_byte: assert property (p_write_on_byte)
    else $error("register changed before a full byte");
  a_fsr_on_byte: assert property (p_fsr_on_byte)
    else $error("wide register changed off a byte boundary");
endmodule : serial_port_checker

// ### testbench/host_model.sv
/*
  Host controller model driving select, serial clock and data in.
  Assumes sys_clk only for aligning frame starts; edges are offset from it.
*/
`timescale 1ns/100ps
module host_model (
  input  wire logic                             sys_clk,
  output serial_access_pkg::serial_pins_t       pins,
  input  wire serial_access_pkg::serial_drive_t drive
);
  realtime halfNs  = 62.5;
  int      pauseAt = -1;

  initial pins = '{1'b1, 1'b0, 1'b0};

  task automatic xfer(input logic [63:0] bits, input int n, output logic [63:0] rx);
    rx = '0;
    @(negedge sys_clk);
    #1.3;
    pins.selectN = 1'b0;
    for (int i = 0; i < n; i++) begin
      pins.serialIn = bits[n-1-i];
      #(halfNs);
      pins.serialClk = 1'b1;
      rx = {rx[62:0], (drive.serialOutEn === 1'b1) ? drive.serialOut : 1'bx};
      #(halfNs);
      pins.serialClk = 1'b0;
      if (i == pauseAt) #2000;
    end
    #(halfNs);
    pins.selectN  = 1'b1;
    // Released line must not keep its last value
    pins.serialIn = ~pins.serialIn;
    #(halfNs);
  endtask : xfer
endmodule : host_model

// ### testbench/serial_register_access_port_tb.sv
/*
  Self-checking bench for the serial register access port.
  Assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/100ps
module serial_register_access_port_tb;
  localparam logic [7:0]  TYPE_VAL  = 8'h5A;    // Arbitrary value
  localparam logic [15:0] MAKER_VAL = 16'h1234; // Arbitrary value
  localparam logic [14:0] RST_A [7] = '{15'h0000, 15'h002B, 15'h004F, 15'h0068,
                                        15'h006E, 15'h0200, 15'h0031};
  localparam logic [7:0]  RST_V [7] = '{8'h30, 8'h11, 8'h13, 8'h61, 8'h88, 8'h01, 8'hA0};
  localparam logic [7:0]  MODES [4] = '{8'h00, 8'h04, 8'h20, 8'h30};
  logic        sys_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic [7:0]  syncPos  = 8'h00;
  logic [7:0]  calState = 8'h00;
  logic [7:0]  calEn;
  logic [15:0] fsrA;
  logic [31:0] seed     = 32'h31322439;
  int          miscompares = 0;
  int          totalChecks = 0;
  serial_access_pkg::serial_pins_t  pins;
  serial_access_pkg::serial_drive_t drive;

  serial_register_access_port #(.PART_TYPE_VALUE(TYPE_VAL), .PART_ID_VALUE(8'hA5),
    .MAKER_ID_VALUE(MAKER_VAL)) dut (.sys_clk(sys_clk), .rstn(rstn), .pins(pins),
    .drive(drive), .syncCapturePosition(syncPos), .calibrationState(calState),
    .calibrationEnable(calEn), .fullScaleRangeA(fsrA));
  host_model host (.sys_clk(sys_clk), .pins(pins), .drive(drive));

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd

  // Descending only when both mirrored step bits are clear
  function automatic logic [15:0] fsrExpect(input logic [7:0] cfg, input logic [7:0] b0,
                                           input logic [7:0] b1);
    return (cfg[5] | cfg[2]) ? {b1, b0} : {b0, b1};
  endfunction : fsrExpect

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Only listed places are written, whatever the calibration state
  task automatic acc(input logic rd, input logic [14:0] a, input logic [15:0] d, input int n,
                     output logic [15:0] q);
    logic [31:0] frame;
    logic [63:0] rx;
    frame = {rd, a, d};
    host.xfer({32'h0, frame >> (32 - n)}, n, rx);
    q = rx[15:0];
  endtask : acc

  initial forever #2.5 sys_clk = ~sys_clk;

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    logic [15:0] q;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  cfg;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(fsrA, 16'hA000);
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, RST_A[i], rnd(), 24, q);
      check(q[7:0], RST_V[i]);
    end
    @(negedge sys_clk) {syncPos, calState} = rnd();
    acc(1'b1, 15'h002C, rnd(), 24, q);
    check(q[7:0], syncPos);
    acc(1'b1, 15'h006A, rnd(), 24, q);
    check(q[7:0], calState);
    acc(1'b1, 15'h000C, rnd(), 32, q);
    check(q, {MAKER_VAL[7:0], MAKER_VAL[15:8]});
    acc(1'b0, 15'h0003, 16'hFF00, 24, q);
    acc(1'b1, 15'h0003, rnd(), 24, q);
    check(q[7:0], TYPE_VAL);
    acc(1'b1, 15'h0005, rnd(), 24, q);
    check(q[7:0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      {b0, b1} = (i == 0) ? 16'h0000 : rnd();
      acc(1'b0, 15'h0061, {b0, 8'h00}, 24, q);
      check(calEn, b0);
      acc(1'b1, 15'h0061, rnd(), 24, q);
      check(q[7:0], b0);
    end
    for (int i = 0; i < 4; i++) begin
      cfg = MODES[i];
      acc(1'b0, 15'h0000, {cfg, 8'h00}, 24, q);
      {b0, b1} = rnd();
      acc(1'b0, (cfg == 8'h00) ? 15'h0031 : 15'h0030, {b0, b1}, 32, q);
      check(fsrA, fsrExpect(cfg, b0, b1));
    end
    acc(1'b0, 15'h0010, 16'h0100, 24, q);
    {b0, b1} = rnd();
    acc(1'b0, 15'h0030, {b0, b1}, 32, q);
    check(fsrA[7:0], b1);
    acc(1'b0, 15'h0010, 16'h0000, 24, q);
    cfg = calEn;
    acc(1'b0, 15'h0061, 16'h5A00, 20, q);
    check(calEn, cfg);
    host.halfNs  = 250.0;
    host.pauseAt = 10;
    {b0, b1} = rnd();
    acc(1'b0, 15'h0061, {b0, 8'h00}, 24, q);
    check(calEn, b0);
    host.halfNs  = 62.5;
    host.pauseAt = -1;
    report_and_stop();
  end
endmodule : serial_register_access_port_tb

bind serial_register_access_port serial_port_checker chk (.sys_clk(sys_clk), .rstn(rstn),
  .pins(pins), .drive(drive), .calibrationEnable(calibrationEnable),
  .fullScaleRangeA(fullScaleRangeA));
